// >>> src/bec_defines.vh
// constants for the bus event count select block
`ifndef BEC_DEFINES_VH
`define BEC_DEFINES_VH
`define BEC_ADDR_W        4
`define BEC_OFF_SEL_A     4'h0
`define BEC_OFF_SEL_B     4'h1
`define BEC_OFF_CFG_0     4'h2
`define BEC_OFF_CFG_1     4'h3
`define BEC_OFF_CFG_2     4'h4
`define BEC_OFF_CFG_3     4'h5
`define BEC_OFF_CNT_0     4'h6
`define BEC_OFF_CNT_1     4'h7
`define BEC_OFF_CNT_2     4'h8
`define BEC_OFF_CNT_3     4'h9
`define BEC_SEL_HI        30
`define BEC_SEL_LO        25
`define BEC_MASK_HI       24
`define BEC_MASK_LO       9
`define BEC_CFG_SEL_HI    15
`define BEC_CFG_SEL_LO    13
`define BEC_CODE_B2B      6'h16
`define BEC_CODE_BNR      6'h08
`define BEC_CODE_SNOOP    6'h06
`define BEC_CODE_RESP     6'h04
`define BEC_CFG_BUS       3'h3
`define BEC_MASK_B2B      16'h007e
`define BEC_MASK_BNR      16'h0007
`define BEC_MASK_SNOOP    16'h00c4
`define BEC_MASK_RESP     16'h0306
`define BEC_SEL_RESET     32'h00000000
`define BEC_CFG_RESET     32'h00000000
`define BEC_UNMAPPED      32'h00000000
`endif

// >>> src/bec_event_match.v
// per-counter event matcher: select code, mask and counter routing
`timescale 1ns/10ps
`include "bec_defines.vh"
module bec_event_match
(
  input  wire [31:0] sel_reg_i,
  input  wire [31:0] cfg_reg_i,
  input  wire [15:0] b2b_i,
  input  wire [15:0] bnr_i,
  input  wire [15:0] snoop_i,
  input  wire [15:0] resp_i,
  output reg         hit_o
);
  wire [5:0]  code;
  wire [15:0] mask;
  wire [2:0]  cfg_sel;
  assign code    = sel_reg_i[`BEC_SEL_HI:`BEC_SEL_LO];
  assign mask    = sel_reg_i[`BEC_MASK_HI:`BEC_MASK_LO];
  assign cfg_sel = cfg_reg_i[`BEC_CFG_SEL_HI:`BEC_CFG_SEL_LO];

  always @*
  begin
    hit_o = 1'b0;
    if (cfg_sel == `BEC_CFG_BUS)
    begin
      case (code)
        `BEC_CODE_B2B:
          hit_o = |(b2b_i & mask & `BEC_MASK_B2B);
        `BEC_CODE_BNR:
          hit_o = |(bnr_i & mask & `BEC_MASK_BNR);
        `BEC_CODE_SNOOP:
          hit_o = |(snoop_i & mask & `BEC_MASK_SNOOP);
        `BEC_CODE_RESP:
          hit_o = |(resp_i & mask & `BEC_MASK_RESP);
        default:
          hit_o = 1'b0;
      endcase
    end
  end
endmodule // bec_event_match

// >>> src/bec_top.v
// bus event selection registers, counter config and four counters
// Notes on behaviour
// - code 16h counts back-to-back cycles, mask 1-6
// - code 08h counts bus-not-ready, mask 0-2
// - code 06h counts snoop hit-modified, mask 2,6,7
// - code 04h counts responses, mask 1,2,8,9
// - select a feeds 0,1; b feeds 2,3; cfg 03h
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "bec_defines.vh"
module bec_top
(
  input  wire                   clk_i,
  input  wire                   reset_i,
  input  wire [`BEC_ADDR_W-1:0] avs_address_i,
  input  wire                   avs_read_i,
  input  wire                   avs_write_i,
  input  wire [31:0]            avs_writedata_i,
  output reg  [31:0]            avs_readdata_o,
  output reg                    avs_waitrequest_o,
  input  wire [15:0]            b2b_ev_i,
  input  wire [15:0]            bnr_ev_i,
  input  wire [15:0]            snoop_ev_i,
  input  wire [15:0]            resp_ev_i,
  output reg  [3:0]             count_pulse_o
);
  localparam ST_IDLE = 2'b01;
  localparam ST_DONE = 2'b10;

  reg  [31:0] bus_event_select_reg_a;
  reg  [31:0] bus_event_select_reg_b;
  reg  [31:0] cfg_reg [0:3];
  reg  [31:0] cnt_reg [0:3];
  reg  [1:0]  state;
  wire [3:0]  hit;
  reg  [31:0] next_readdata;
  integer     i;

  // a request gets one wait cycle, then completes
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state             <= ST_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (avs_read_i || avs_write_i)
          begin
            state             <= ST_DONE;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= next_readdata;
          end
          else
          begin
            avs_waitrequest_o <= 1'b1;
          end
        end
        ST_DONE:
        begin
          state             <= ST_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default:
        begin
          state             <= ST_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  wire wr_take;
  assign wr_take = (state == ST_DONE) && avs_write_i;

  always @*
  begin
    next_readdata = `BEC_UNMAPPED;
    case (avs_address_i)
      `BEC_OFF_SEL_A: next_readdata = bus_event_select_reg_a;
      `BEC_OFF_SEL_B: next_readdata = bus_event_select_reg_b;
      `BEC_OFF_CFG_0: next_readdata = cfg_reg[0];
      `BEC_OFF_CFG_1: next_readdata = cfg_reg[1];
      `BEC_OFF_CFG_2: next_readdata = cfg_reg[2];
      `BEC_OFF_CFG_3: next_readdata = cfg_reg[3];
      `BEC_OFF_CNT_0: next_readdata = cnt_reg[0];
      `BEC_OFF_CNT_1: next_readdata = cnt_reg[1];
      `BEC_OFF_CNT_2: next_readdata = cnt_reg[2];
      `BEC_OFF_CNT_3: next_readdata = cnt_reg[3];
      default:        next_readdata = `BEC_UNMAPPED;
    endcase
  end

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bus_event_select_reg_a <= `BEC_SEL_RESET;
      bus_event_select_reg_b <= `BEC_SEL_RESET;
    end
    else if (wr_take)
    begin
      if (avs_address_i == `BEC_OFF_SEL_A)
        bus_event_select_reg_a <= avs_writedata_i;
      if (avs_address_i == `BEC_OFF_SEL_B)
        bus_event_select_reg_b <= avs_writedata_i;
    end
  end

  // counter registers: a write in the same cycle as an event wins
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        cfg_reg[i] <= `BEC_CFG_RESET;
        cnt_reg[i] <= 32'h00000000;
      end
      count_pulse_o <= 4'h0;
    end
    else
    begin
      count_pulse_o <= hit;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (wr_take && (avs_address_i == `BEC_OFF_CFG_0 + i[3:0]))
          cfg_reg[i] <= avs_writedata_i;
        if (wr_take && (avs_address_i == `BEC_OFF_CNT_0 + i[3:0]))
          cnt_reg[i] <= avs_writedata_i;
        else if (hit[i])
          cnt_reg[i] <= cnt_reg[i] + 32'h00000001;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_match
      // counters 0,1 follow select a, counters 2,3 follow select b
      bec_event_match u_match
      (
        .sel_reg_i (g < 2 ? bus_event_select_reg_a
                          : bus_event_select_reg_b),
        .cfg_reg_i (cfg_reg[g]),
        .b2b_i     (b2b_ev_i),
        .bnr_i     (bnr_ev_i),
        .snoop_i   (snoop_ev_i),
        .resp_i    (resp_ev_i),
        .hit_o     (hit[g])
      );
    end
  endgenerate
endmodule // bec_top

// >>> verif/bec_checker.sv
// checker: register shadow and counter pulse properties
`timescale 1ns/10ps
module bec_checker
(
  input wire        clk_i,
  input wire        reset_i,
  input wire [3:0]  avs_address_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire        avs_waitrequest_o,
  input wire [15:0] b2b_ev_i,
  input wire [15:0] bnr_ev_i,
  input wire [15:0] snoop_ev_i,
  input wire [15:0] resp_ev_i,
  input wire [3:0]  count_pulse_o
);
  logic [31:0] r [0:5];
  // events come in as arguments so that properties see sampled values
  function logic h(logic [31:0] s, c, int k, logic [15:0] e);
    logic [15:0] m;
    m = s[24:9];
    case (k)
      0: h = s[30:25] == 6'h16 && |(e & m & 16'h7e);
      1: h = s[30:25] == 6'h08 && |(e & m & 16'h7);
      2: h = s[30:25] == 6'h06 && |(e & m & 16'hc4);
      default: h = s[30:25] == 6'h04 && |(e & m & 16'h306);
    endcase
    h = h && c[15:13] == 3'h3;
  endfunction
  function logic a(logic [31:0] s, c, logic [15:0] e0, e1, e2, e3);
    a = h(s, c, 0, e0) | h(s, c, 1, e1) | h(s, c, 2, e2) | h(s, c, 3, e3);
  endfunction
  always @(posedge clk_i or posedge reset_i)
    if (reset_i)
      r <= '{default: 32'h0};
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i < 4'h6)
      r[avs_address_i] <= avs_writedata_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_b2b;
    h(r[0], r[2], 0, b2b_ev_i) |=> count_pulse_o[0];
  endproperty
  property p_bnr;
    h(r[0], r[3], 1, bnr_ev_i) |=> count_pulse_o[1];
  endproperty
  property p_snp;
    h(r[1], r[4], 2, snoop_ev_i) |=> count_pulse_o[2];
  endproperty
  property p_rsp;
    h(r[1], r[5], 3, resp_ev_i) |=> count_pulse_o[3];
  endproperty
  property p_route;
    !a(r[1], r[4], b2b_ev_i, bnr_ev_i, snoop_ev_i, resp_ev_i)
      |=> !count_pulse_o[2];
  endproperty
  property p_mask;
    !a(r[0], r[2], b2b_ev_i, bnr_ev_i, snoop_ev_i, resp_ev_i)
      |=> !count_pulse_o[0];
  endproperty
  a_b2b: assert property (p_b2b) else $error("b2b missed");
  a_bnr: assert property (p_bnr) else $error("bnr missed");
  a_snp: assert property (p_snp) else $error("snoop missed");
  a_rsp: assert property (p_rsp) else $error("resp missed");
  a_route: assert property (p_route) else $error("bad route");
  a_mask: assert property (p_mask) else $error("masked count");
  cover property (count_pulse_o[0]);
  cover property (count_pulse_o[3]);
  cover property (avs_write_i && !avs_waitrequest_o);
endmodule // bec_checker
bind bec_top bec_checker chk (.*);

// >>> verif/bec_evsrc.sv
// far side model: bus event strobes, one cycle per request
`timescale 1ns/10ps
module bec_evsrc
(
  input  wire        clk_i,
  input  wire        go_i,
  input  wire [1:0]  sel_i,
  input  wire [15:0] pat_i,
  output reg  [63:0] ev_o = 64'h0
);
  always @(posedge clk_i)
    ev_o <= go_i ? {48'h0, pat_i} << (sel_i * 16) : 64'h0;
endmodule // bec_evsrc

// >>> verif/tb_top.sv
// bench: register access, event routing and counting
`timescale 1ns/10ps
module tb_top;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, go = 0, wt, ha, hb;
  logic [1:0]  k = 0;
  logic [3:0]  adr = 0, pl;
  logic [15:0] x = 16'h6, pat = 0, ma, mb, pt;
  logic [31:0] wd = 0, q, rdat;
  logic [63:0] ev;
  int          fails = 0, checks_done = 0, cnt = 0;
  bit   [5:0]  cd [4] = '{6'h16, 6'h08, 6'h06, 6'h04};
  bit   [15:0] al [4] = '{16'h7e, 16'h7, 16'hc4, 16'h306};
  always #50 clk = ~clk;
  bec_top dut (.clk_i(clk), .reset_i(rst), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .b2b_ev_i(ev[15:0]),
    .bnr_ev_i(ev[31:16]), .snoop_ev_i(ev[47:32]),
    .resp_ev_i(ev[63:48]), .count_pulse_o(pl));
  bec_evsrc src (.clk_i(clk), .go_i(go), .sel_i(k), .pat_i(pat), .ev_o(ev));
  function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task cmp(input [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task acc(input w, input [3:0] a, input [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wt !== 1'b0)
      @(posedge clk);
    q = rdat;
    wr <= 0;
    rd <= 0;
    @(posedge clk);
  endtask
  task summarize;
    $display("fails=%0d checks_done=%0d", fails, checks_done);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    fails++;
    summarize;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    acc(0, 4'h0, 0);
    cmp(q, 0);
    acc(1, 4'hf, 32'hffffffff);
    acc(0, 4'hf, 0);
    cmp(q, 0);
    for (int i = 0; i < 8; i++)
    begin
      x = nx(x);
      ma = i < 4 ? 16'hffff : x;
      x = nx(x);
      mb = i < 4 ? 16'h0 : x;
      x = nx(x);
      pt = i < 4 ? 16'hffff : x;
      acc(1, 4'h0, {1'b0, cd[i % 4], ma, 9'h0});
      acc(1, 4'h1, {1'b0, cd[i % 4], mb, 9'h0});
      for (int n = 2; n < 6; n++)
        acc(1, n[3:0], {16'h0, (n == 5 && !i[0]) ? i[2:0] : 3'h3, 13'h0});
      ha = |(pt & ma & al[i % 4]);
      hb = |(pt & mb & al[i % 4]);
      k <= i[1:0];
      pat <= pt;
      go <= 1;
      @(posedge clk);
      go <= 0;
      repeat (2) @(posedge clk);
      cmp(pl, {hb & i[0], hb, ha, ha});
      cnt += ha;
      acc(0, 4'h6, 0);
      cmp(q, cnt);
    end
    summarize;
  end
endmodule // tb_top
